// >>> logic/temp_monitor.sv
// Two-channel temperature monitor core with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_regs.svh"
module temp_monitor #(
  parameter int FAST_PERIOD_CYC = `FAST_PERIOD_US * `CLK_MHZ,
  parameter int TIMEOUT_CYC     = `SMB_TIMEOUT_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // AXI4-Lite write
  input wire logic        awvalid,
  output logic            awready,
  input wire logic [7:0]  awaddr,
  input wire logic        wvalid,
  output logic            wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  output logic            bvalid,
  input wire logic        bready,
  output logic [1:0]      bresp,
  // AXI4-Lite read
  input wire logic        arvalid,
  output logic            arready,
  input wire logic [7:0]  araddr,
  output logic            rvalid,
  input wire logic        rready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  // Converter front end
  output logic            adcStart,
  output logic            adcRemote,
  input wire logic        adcDone,
  input wire logic [11:0] adcData,
  // Alarm and address pins
  output logic            critPinOut,
  output logic            critPinOe,
  input wire logic        osPinIn,
  output logic            osPinOut,
  output logic            osPinOe,
  input wire logic [1:0]  addrLevel,
  output logic [6:0]      slaveAddr,
  // Serial bus clock watch
  input wire logic        smbClkIn,
  output logic            smbRelease
);
  typedef struct packed {
    logic        awRdy;
    logic        wRdy;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arRdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  cfg;
    logic [2:0]  rate;
    logic [11:0] offset;
    logic [7:0]  critLim;
    logic [7:0]  otLim;
    logic [7:0]  hyst;
    logic [3:0]  mask;
    logic [13:0] remoteF;
    logic [11:0] localT;
    logic        oneShot;
    logic [23:0] lowCnt;
    logic        release_;
    logic        timeout;
    logic [6:0]  addr;
    logic        addrDone;
    logic        adcStart;
    logic        adcRemote;
    logic        critOe;
    logic        osOe;
  } core_t;
  core_t s_q;
  core_t s_d;
  conv_if cv ();
  logic critAlarm;
  logic otAlarm;
  temp_monitor_pkg::temp_t remoteT;
  logic signed [12:0] corr;
  temp_monitor_pkg::temp_t v;
  logic signed [15:0] acc;
  logic [31:0] wv;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clamp to the 11-bit range of the selected format
  function automatic logic [10:0] fmt11(input temp_monitor_pkg::temp_t t, input logic uns);
    if (uns) begin
      fmt11 = (t < 0) ? 11'h000 : t[10:0];
    end else if (t > 12'sh3ff) begin
      fmt11 = 11'h3ff;
    end else if (t < 12'shc00) begin
      fmt11 = 11'h400;
    end else begin
      fmt11 = t[10:0];
    end
  endfunction : fmt11

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `OFS_CONFIG, `OFS_RATE, `OFS_ONESHOT, `OFS_REMOTE, `OFS_LOCAL, `OFS_OFFSET,
      `OFS_CRIT, `OFS_OVERTEMP, `OFS_HYST, `OFS_MASK, `OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic [31:0] regVal(input core_t s, input logic [7:0] a,
                                         input logic pinIn, input logic busy);
    regVal = '0;
    case (a)
      `OFS_CONFIG:   regVal[3:0] = s.cfg;
      `OFS_RATE:     regVal[2:0] = s.rate;
      `OFS_REMOTE:   regVal[10:0] = fmt11(s.remoteF[13:2], s.cfg[`CFG_UNSIGNED]);
      `OFS_LOCAL:    regVal[10:0] = fmt11(s.localT, s.cfg[`CFG_UNSIGNED]);
      `OFS_OFFSET:   regVal[11:0] = s.offset;
      `OFS_CRIT:     regVal[7:0] = s.critLim;
      `OFS_OVERTEMP: regVal[7:0] = s.otLim;
      `OFS_HYST:     regVal[7:0] = s.hyst;
      `OFS_MASK:     regVal[3:0] = s.mask;
      `OFS_STATUS: begin
        regVal[`ST_CRIT] = s.critOe;
        regVal[`ST_OT] = otAlarm;
        regVal[`ST_OS_PIN] = pinIn;
        regVal[`ST_BUSY] = busy;
        regVal[`ST_TIMEOUT] = s.timeout;
        regVal[`ST_ADDR_LSB +: 7] = s.addr;
      end
      default:       regVal = '0;
    endcase
  endfunction : regVal

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  assign cv.done = adcDone;
  assign remoteT = s_q.remoteF[13:2];

  conv_seq #(
    .FAST_PERIOD_CYC (FAST_PERIOD_CYC)
  ) u_seq (
    .core_clk (core_clk),
    .reset    (reset),
    .standby  (s_q.cfg[`CFG_STANDBY]),
    .oneShot  (s_q.oneShot),
    .rate     (s_q.rate),
    .cv       (cv.seq)
  );

  alarm_eval u_crit (
    .core_clk (core_clk),
    .reset    (reset),
    .remoteT  (remoteT),
    .localT   (s_q.localT),
    .limit    (s_q.critLim),
    .hyst     (s_q.hyst),
    .mask     ({s_q.mask[`MSK_LOC_CRIT], s_q.mask[`MSK_REM_CRIT]}),
    .alarm    (critAlarm)
  );

  alarm_eval u_ot (
    .core_clk (core_clk),
    .reset    (reset),
    .remoteT  (remoteT),
    .localT   (s_q.localT),
    .limit    (s_q.otLim),
    .hyst     (s_q.hyst),
    .mask     ({s_q.mask[`MSK_LOC_OT], s_q.mask[`MSK_REM_OT]}),
    .alarm    (otAlarm)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.oneShot = 1'b0;
    wv = merge(regVal(s_q, s_q.awAddr, osPinIn, cv.busy), s_q.wData, s_q.wStrb);
    corr = $signed({adcData[11], adcData}) + $signed({s_q.offset[11], s_q.offset});
    if (corr > 13'sh07ff) begin
      v = 12'sh7ff;
    end else if (corr < 13'sh1800) begin
      v = 12'sh800;
    end else begin
      v = corr[11:0];
    end
    // Filter keeps two extra fraction bits: new = (3 * old + sample) / 4
    acc = 16'(3 * $signed({{2{s_q.remoteF[13]}}, s_q.remoteF})) +
          $signed({{2{v[11]}}, v, 2'h0});
    // Write channels, taken in either order
    if (awvalid && s_q.awRdy) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && s_q.wRdy) begin
      s_d.wHeld = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awHeld && s_q.wHeld && !s_q.bvalid) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_q.awAddr)
        `OFS_CONFIG:   s_d.cfg = wv[3:0];
        `OFS_RATE:     s_d.rate = wv[2:0];
        `OFS_ONESHOT:  s_d.oneShot = 1'b1;
        `OFS_OFFSET:   s_d.offset = wv[11:0];
        `OFS_CRIT:     s_d.critLim = wv[7:0];
        `OFS_OVERTEMP: s_d.otLim = wv[7:0];
        `OFS_HYST:     s_d.hyst = wv[7:0];
        `OFS_MASK:     s_d.mask = wv[3:0];
        `OFS_STATUS: begin
          if (s_q.wStrb[0] && s_q.wData[`ST_TIMEOUT]) begin
            s_d.timeout = 1'b0;
          end
        end
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    s_d.awRdy = !s_d.awHeld && !s_d.bvalid;
    s_d.wRdy = !s_d.wHeld && !s_d.bvalid;
    // Read channel
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arRdy) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = regVal(s_q, araddr, osPinIn, cv.busy);
      s_d.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    s_d.arRdy = !s_d.rvalid;
    // Conversion results
    s_d.adcStart = cv.start;
    s_d.adcRemote = cv.chan;
    if (adcDone && s_q.adcRemote) begin
      s_d.remoteF = s_q.cfg[`CFG_FILTER] ? acc[15:2] : {v, 2'h0};
    end else if (adcDone) begin
      s_d.localT = adcData;
    end
    // Pins: both open drain, low only while the enable is on
    s_d.critOe = critAlarm;
    s_d.osOe = s_q.cfg[`CFG_PIN_OUT] && otAlarm;
    // Clock-low watch; a new timeout wins over a clear in the same cycle
    if (smbClkIn) begin
      s_d.lowCnt = '0;
      s_d.release_ = 1'b0;
    end else if (s_q.lowCnt == 24'(TIMEOUT_CYC - 1)) begin
      s_d.release_ = 1'b1;
      s_d.timeout = 1'b1;
    end else begin
      s_d.lowCnt = s_q.lowCnt + 24'h000001;
    end
    // Address strap caught in the first cycle after reset release
    if (!s_q.addrDone) begin
      s_d.addrDone = 1'b1;
      case (addrLevel)
        `LVL_LOW:  s_d.addr = `ADDR_LOW;
        `LVL_HIGH: s_d.addr = `ADDR_HIGH;
        default:   s_d.addr = `ADDR_MID;
      endcase
    end
    if (reset) begin
      s_d = '0;
      s_d.critLim = `RST_CRIT;
      s_d.otLim = `RST_OT;
      s_d.hyst = `RST_HYST;
      s_d.rate = `RST_RATE;
      s_d.addr = `ADDR_MID;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = s_q.awRdy;
  assign wready = s_q.wRdy;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arRdy;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign adcStart = s_q.adcStart;
  assign adcRemote = s_q.adcRemote;
  assign critPinOut = 1'b0;
  assign critPinOe = s_q.critOe;
  assign osPinOut = 1'b0;
  assign osPinOe = s_q.osOe;
  assign slaveAddr = s_q.addr;
  assign smbRelease = s_q.release_;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence bothHeld;
    s_q.awHeld && s_q.wHeld && !s_q.bvalid;
  endsequence
  sequence answered;
    bvalid && !awready && !wready;
  endsequence

  chk_write_answer: assert property (bothHeld |=> answered)
    else $error("write response not given one cycle after address and data");
  chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not returned on the next cycle");
  chk_crit_pin: assert property ($rose(critAlarm) |=> critPinOe && !critPinOut)
    else $error("critical pin not pulled low after alarm");
  chk_os_as_addr: assert property (!s_q.cfg[`CFG_PIN_OUT] |=> !osPinOe)
    else $error("shared pin driven while it is the address input");
  chk_os_as_alarm: assert property (s_q.cfg[`CFG_PIN_OUT] && otAlarm |=> osPinOe)
    else $error("over-temperature pin not driven in output mode");
  chk_addr_legal: assert property (s_q.addrDone |-> slaveAddr inside
                                   {`ADDR_LOW, `ADDR_MID, `ADDR_HIGH})
    else $error("slave address outside the three selectable values");
  chk_addr_held: assert property (s_q.addrDone |=> $stable(slaveAddr))
    else $error("slave address changed after it was latched");
  chk_limit_reset: assert property ($fell(reset) |-> s_q.critLim == `RST_CRIT
                                    && s_q.otLim == `RST_OT)
    else $error("alarm limits not at their reset defaults");
  chk_local_capture: assert property (adcDone && !s_q.adcRemote |=>
                                      s_q.localT == $past(adcData))
    else $error("local result not stored from converter");
  chk_timeout_flag: assert property (!smbClkIn && s_q.lowCnt == 24'(TIMEOUT_CYC - 1)
                                     |=> smbRelease && s_q.timeout)
    else $error("bus clock timeout not flagged");
  chk_status_mirror: assert property (rvalid && $past(arvalid && arready
                                      && araddr == `OFS_STATUS) |->
                                      rdata[`ST_CRIT] == $past(critPinOe))
    else $error("status does not mirror the critical pin");
endmodule : temp_monitor
`default_nettype wire

// >>> logic/temp_monitor_regs.svh
// Register offsets, field positions, reset values and timing constants of the temperature monitor
`ifndef TEMP_MONITOR_REGS_SVH
`define TEMP_MONITOR_REGS_SVH
`define OFS_CONFIG    8'h00
`define OFS_RATE      8'h04
`define OFS_ONESHOT   8'h08
`define OFS_REMOTE    8'h0c
`define OFS_LOCAL     8'h10
`define OFS_OFFSET    8'h14
`define OFS_CRIT      8'h18
`define OFS_OVERTEMP  8'h1c
`define OFS_HYST      8'h20
`define OFS_MASK      8'h24
`define OFS_STATUS    8'h28
`define CFG_STANDBY   0
`define CFG_UNSIGNED  1
`define CFG_FILTER    2
`define CFG_PIN_OUT   3
`define MSK_REM_CRIT  0
`define MSK_LOC_CRIT  1
`define MSK_REM_OT    2
`define MSK_LOC_OT    3
`define ST_CRIT       0
`define ST_OT         1
`define ST_OS_PIN     2
`define ST_BUSY       3
`define ST_TIMEOUT    4
`define ST_ADDR_LSB   8
`define RST_CRIT      8'h6e
`define RST_OT        8'h55
`define RST_HYST      8'h0a
`define RST_RATE      3'h1
`define ADDR_LOW      7'h18
`define ADDR_MID      7'h29
`define ADDR_HIGH     7'h4c
`define LVL_LOW       2'h1
`define LVL_HIGH      2'h2
`define RATE_0P4HZ    3'h0
`define RATE_1HZ      3'h1
`define RATE_2HZ      3'h2
`define RATE_4HZ      3'h3
`define RATE_8HZ      3'h4
`define MULT_0P4HZ    6'h28
`define MULT_1HZ      6'h10
`define MULT_2HZ      6'h08
`define MULT_4HZ      6'h04
`define MULT_8HZ      6'h02
`define MULT_16HZ     6'h01
`define CLK_MHZ       10
`define FAST_PERIOD_US 62500
`define SMB_TIMEOUT_US 25000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// >>> logic/temp_monitor_pkg.sv
// Shared types of the temperature monitor
package temp_monitor_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b001,
    SEQ_REMOTE = 3'b010,
    SEQ_LOCAL  = 3'b100
  } seq_state_t;
  // Temperature in eighths of a degree, two's complement
  typedef logic signed [11:0] temp_t;
endpackage : temp_monitor_pkg

// >>> logic/conv_if.sv
// Handshake between the conversion sequencer and the monitor core
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic start;
  logic chan;
  logic busy;
  logic done;
  modport seq (output start, output chan, output busy, input done);
  modport core (input start, input chan, input busy, output done);
endinterface : conv_if
`default_nettype wire

// >>> logic/conv_seq.sv
// Conversion rate timer, standby and one-shot sequencing of both channels
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_regs.svh"
module conv_seq #(
  parameter int FAST_PERIOD_CYC = `FAST_PERIOD_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // Control
  input wire logic       standby,
  input wire logic       oneShot,
  input wire logic [2:0] rate,
  // Toward the core
  conv_if.seq            cv
);
  typedef struct packed {
    temp_monitor_pkg::seq_state_t st;
    logic [23:0]                  baseCnt;
    logic [5:0]                   multCnt;
    logic                         pend;
    logic                         start;
    logic                         chan;
  } seq_t;
  seq_t s_q;
  seq_t s_d;
  logic tick;

  function automatic logic [5:0] mult(input logic [2:0] r);
    case (r)
      `RATE_0P4HZ: mult = `MULT_0P4HZ;
      `RATE_1HZ:   mult = `MULT_1HZ;
      `RATE_2HZ:   mult = `MULT_2HZ;
      `RATE_4HZ:   mult = `MULT_4HZ;
      `RATE_8HZ:   mult = `MULT_8HZ;
      default:     mult = `MULT_16HZ;
    endcase
  endfunction : mult

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    tick = 1'b0;
    if (standby) begin
      s_d.baseCnt = '0;
      s_d.multCnt = '0;
    end else if (s_q.baseCnt == 24'(FAST_PERIOD_CYC - 1)) begin
      s_d.baseCnt = '0;
      if (s_q.multCnt >= mult(rate) - 6'h01) begin
        s_d.multCnt = '0;
        tick = 1'b1;
      end else begin
        s_d.multCnt = s_q.multCnt + 6'h01;
      end
    end else begin
      s_d.baseCnt = s_q.baseCnt + 24'h000001;
    end
    // A one-shot in standby during a running cycle is kept, not dropped; outside standby it is ignored
    if (standby && oneShot) begin
      s_d.pend = 1'b1;
    end
    case (s_q.st)
      temp_monitor_pkg::SEQ_IDLE: begin
        if (tick || s_d.pend) begin
          s_d.pend = 1'b0;
          s_d.start = 1'b1;
          s_d.chan = 1'b1;
          s_d.st = temp_monitor_pkg::SEQ_REMOTE;
        end
      end
      temp_monitor_pkg::SEQ_REMOTE: begin
        if (cv.done) begin
          s_d.start = 1'b1;
          s_d.chan = 1'b0;
          s_d.st = temp_monitor_pkg::SEQ_LOCAL;
        end
      end
      temp_monitor_pkg::SEQ_LOCAL: begin
        if (cv.done) begin
          s_d.st = temp_monitor_pkg::SEQ_IDLE;
        end
      end
      default: s_d.st = temp_monitor_pkg::SEQ_IDLE;
    endcase
    if (reset) begin
      s_d = '0;
      s_d.st = temp_monitor_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign cv.start = s_q.start;
  assign cv.chan = s_q.chan;
  assign cv.busy = (s_q.st != temp_monitor_pkg::SEQ_IDLE);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence quietIdle;
    standby && !oneShot && !s_q.pend && s_q.st == temp_monitor_pkg::SEQ_IDLE;
  endsequence
  sequence oneShotIdle;
    standby && oneShot && s_q.st == temp_monitor_pkg::SEQ_IDLE;
  endsequence
  chk_standby_quiet: assert property (quietIdle |=> !cv.start)
    else $error("conversion started in standby without one-shot");
  chk_one_shot_start: assert property (oneShotIdle |=> cv.start && cv.chan)
    else $error("one-shot did not start a remote conversion");
endmodule : conv_seq
`default_nettype wire

// >>> logic/alarm_eval.sv
// Alarm comparator with shared hysteresis over both channels
`timescale 1ns/1ps
`default_nettype none
module alarm_eval (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    reset,
  // Inputs
  input wire temp_monitor_pkg::temp_t remoteT,
  input wire temp_monitor_pkg::temp_t localT,
  input wire logic [7:0]              limit,
  input wire logic [7:0]              hyst,
  input wire logic [1:0]              mask,
  // Result
  output logic                        alarm
);
  typedef struct packed {
    logic alarm;
  } alarm_t;
  alarm_t s_q;
  alarm_t s_d;
  logic signed [12:0] hi;
  logic signed [12:0] lo;
  logic over;
  logic allBelow;

  always_comb begin
    hi = {2'h0, limit, 3'h0};
    lo = hi - $signed({2'h0, hyst, 3'h0});
    over = (!mask[0] && remoteT > hi) || (!mask[1] && localT > hi);
    allBelow = (mask[0] || remoteT < lo) && (mask[1] || localT < lo);
    s_d = s_q;
    s_d.alarm = s_q.alarm ? !allBelow : over;
    if (reset) begin
      s_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign alarm = s_q.alarm;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_alarm_rise: assert property ($rose(alarm) |-> $past(over))
    else $error("alarm set without an unmasked channel over limit");
  chk_alarm_hold: assert property (alarm && !allBelow |=> alarm)
    else $error("alarm released before all channels fell below hysteresis");
endmodule : alarm_eval
`default_nettype wire

// >>> verification/adc_front_model.sv
// Behavioural converter front end that answers each start after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module adc_front_model #(
  parameter int         DELAY      = 3,
  parameter logic [11:0] REMOTE_VAL = 12'h3c0,
  parameter logic [11:0] LOCAL_VAL  = 12'h0c8
) (
  // Clock
  input wire logic        core_clk,
  // Request
  input wire logic        adcStart,
  input wire logic        adcRemote,
  // Answer
  output logic            adcDone = 1'b0,
  output logic [11:0]     adcData = 12'h000,
  output int              starts = 0
);
  int   cnt = 0;
  logic chan = 1'b0;
  always @(posedge core_clk) begin
    adcDone <= 1'b0;
    // Data only holds with the done pulse, so it toggles otherwise
    adcData <= ~adcData;
    if (adcStart) begin
      cnt    <= DELAY;
      chan   <= adcRemote;
      starts <= starts + 1;
    end else if (cnt == 1) begin
      adcDone <= 1'b1;
      adcData <= chan ? REMOTE_VAL : LOCAL_VAL;
      cnt     <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : adc_front_model
`default_nettype wire

// >>> verification/dual_channel_temp_monitor_tb.sv
// Register-level testbench of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_regs.svh"
module dual_channel_temp_monitor_tb;
  logic core_clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, smbClkIn = 1'b1, osPinIn;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [1:0] bresp, rresp, addrLevel = 2'h2, resp;
  logic awready, wready, bvalid, arready, rvalid, adcStart, adcRemote, adcDone;
  logic critPinOut, critPinOe, osPinOut, osPinOe, smbRelease;
  logic [11:0] adcData;
  logic [6:0] slaveAddr;
  int starts, numErrors = 0, numChecks = 0, n, base;
  // Shared pin pull-up: reads high unless the device pulls it low
  assign osPinIn = !osPinOe;
  temp_monitor #(.FAST_PERIOD_CYC(20), .TIMEOUT_CYC(16)) dut_u (.core_clk(core_clk),
    .reset(reset), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .adcStart(adcStart),
    .adcRemote(adcRemote), .adcDone(adcDone), .adcData(adcData), .critPinOut(critPinOut),
    .critPinOe(critPinOe), .osPinIn(osPinIn), .osPinOut(osPinOut), .osPinOe(osPinOe),
    .addrLevel(addrLevel), .slaveAddr(slaveAddr), .smbClkIn(smbClkIn),
    .smbRelease(smbRelease));
  adc_front_model conv_u (.core_clk(core_clk), .adcStart(adcStart), .adcRemote(adcRemote),
    .adcDone(adcDone), .adcData(adcData), .starts(starts));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : closeOut
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Bounded waits: a hang counts as a mismatch and ends the run
  task automatic hang(input int k);
    if (k >= 200) begin
      numErrors++;
      closeOut();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0; resp = bresp; break;
      end
    end
    hang(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0; got = rdata; resp = rresp; break;
      end
    end
    hang(n);
  endtask : rd
  // One-shot conversion; waits for the local channel to finish
  task automatic shot();
    wr(`OFS_ONESHOT, 32'h1);
    for (n = 0; n < 200 && !(adcDone && !adcRemote); n++) @(posedge core_clk);
    hang(n);
    repeat (40) @(posedge core_clk);
  endtask : shot
  // Reset again in mid-run; the strap moves first so the new level must be latched after release
  task automatic reboot(input logic [1:0] lvl);
    addrLevel <= lvl;
    repeat (2) @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : reboot
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({25'h0, slaveAddr}, 32'h4c);
    rd(`OFS_CRIT); chk(got, 32'h6e);
    rd(`OFS_OVERTEMP); chk(got, 32'h55);
    rd(`OFS_STATUS); chk(got[14:8], 32'h4c);
    rd(8'h3c); chk(resp, `RESP_SLVERR); chk(got, 32'h0);
    wr(8'h3c, 32'h1); chk(resp, `RESP_SLVERR);
    $display("test reset values done");
    wr(`OFS_CONFIG, 32'h1); chk(resp, `RESP_OKAY);
    repeat (60) @(posedge core_clk);
    base = starts;
    shot();
    chk(starts - base, 32'h2);
    rd(`OFS_REMOTE); chk(got, 32'h3c0);
    rd(`OFS_LOCAL); chk(got, 32'h0c8);
    chk({critPinOe, critPinOut}, 32'h2);
    rd(`OFS_STATUS); chk(got[1:0], 32'h3);
    $display("test one-shot in standby done");
    wr(`OFS_MASK, 32'h1); wr(`OFS_CONFIG, 32'h9); shot();
    chk({critPinOe, osPinOe, osPinOut}, 32'h2);
    rd(`OFS_STATUS); chk(got[3:0], 32'h2);
    wr(`OFS_OVERTEMP, 32'h7d); rd(`OFS_STATUS); chk(got[2:1], 32'h1);
    wr(`OFS_HYST, 32'h0); rd(`OFS_STATUS); chk(got[2:1], 32'h2);
    $display("test mask, shared pin and hysteresis done");
    wr(`OFS_OFFSET, 32'hff0); shot();
    rd(`OFS_REMOTE); chk(got, 32'h3b0);
    wr(`OFS_OFFSET, 32'h0); wr(`OFS_CONFIG, 32'hd); shot();
    rd(`OFS_REMOTE); chk(got, 32'h3b4);
    wr(`OFS_CONFIG, 32'h9); wr(`OFS_OFFSET, 32'h100); shot();
    rd(`OFS_OFFSET); chk(got, 32'h100);
    rd(`OFS_REMOTE); chk(got, 32'h3ff);
    wr(`OFS_CONFIG, 32'hb); rd(`OFS_REMOTE); chk(got, 32'h4c0);
    $display("test offset, filter and format done");
    wr(`OFS_RATE, 32'h5); wr(`OFS_CONFIG, 32'h0); base = starts;
    repeat (80) @(posedge core_clk);
    chk(starts > base, 32'h1);
    smbClkIn <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(smbRelease, 32'h1);
    rd(`OFS_STATUS); chk(got[4], 32'h1);
    smbClkIn <= 1'b1;
    wr(`OFS_STATUS, 32'h10); rd(`OFS_STATUS); chk(got[4], 32'h0);
    chk(smbRelease, 32'h0);
    $display("test periodic and timeout done");
    reboot(2'h1); chk({25'h0, slaveAddr}, 32'h18);
    rd(`OFS_OVERTEMP); chk(got, 32'h55);
    reboot(2'h0); chk({25'h0, slaveAddr}, 32'h29);
    $display("test mid-run reset done");
    closeOut();
  end
endmodule : dual_channel_temp_monitor_tb
`default_nettype wire
